/* File: cfh_pkg.sv */
package cfh_pkg;
  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_GEOM = 8'h08;
  localparam logic [7:0] OFS_FILE = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_PTR = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_MADR = 8'h1C;
  localparam logic [7:0] OFS_MDAT = 8'h20;
  localparam logic [7:0] OFS_SEL = 8'h24;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CMD_INS_LSB = 0;
  localparam int unsigned CMD_P1_LSB = 8;
  localparam int unsigned CMD_P2_LSB = 16;
  localparam int unsigned CMD_LE_LSB = 24;
  localparam int unsigned GEOM_LC_LSB = 0;
  localparam int unsigned GEOM_SIZE_LSB = 8;
  localparam int unsigned FILE_ST_LSB = 0;
  localparam int unsigned FILE_RDOK_BIT = 2;
  localparam int unsigned FILE_UPOK_BIT = 3;
  localparam int unsigned FILE_RLEN_LSB = 8;
  localparam int unsigned FILE_NREC_LSB = 16;
  localparam int unsigned FILE_SFR_LSB = 24;
  localparam int unsigned SEL_FCP_LSB = 0;
  localparam int unsigned SEL_DFN_LSB = 8;
  // ************************************************************
  // Command and parameter coding
  // ************************************************************
  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [7:0] CMD_RD_BIN = 8'h01;
  localparam logic [7:0] CMD_UPD_BIN = 8'h02;
  localparam logic [7:0] CMD_RD_REC = 8'h03;
  localparam logic [7:0] P2_SEL = 8'h00;
  localparam logic [7:0] P2_DFNAME = 8'h01;
  localparam logic [7:0] P2_NODATA = 8'h0C;
  localparam logic [2:0] P1_SFR_TAG = 3'h4;
  localparam logic [2:0] MODE_NEXT = 3'h2;
  localparam logic [2:0] MODE_PREV = 3'h3;
  localparam logic [2:0] MODE_ABS = 3'h4;
  localparam logic [1:0] FS_TRANSP = 2'h0;
  localparam logic [1:0] FS_LINEAR = 2'h1;
  localparam logic [1:0] FS_CYCLIC = 2'h2;
  localparam logic [7:0] FCP_BASE = 8'hC0;
  localparam logic [7:0] DFN_BASE = 8'hE0;
  // ************************************************************
  // Status words
  // ************************************************************
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_LEN = 16'h6700;
  localparam logic [15:0] SW_STRUCT = 16'h6981;
  localparam logic [15:0] SW_SEC = 16'h6982;
  localparam logic [15:0] SW_NOFILE = 16'h6A82;
  localparam logic [15:0] SW_NOREC = 16'h6A83;
  localparam logic [15:0] SW_P1P2 = 16'h6A86;
  localparam logic [15:0] SW_OFFSET = 16'h6B00;
  localparam logic [15:0] SW_INS = 16'h6D00;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_RECV = 3'b100
  } cfh_state_e;
endpackage

/* File: cfh_top.sv */
`timescale 1ns/100ps
module cfh_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cfh_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [cfh_pkg::DW-1:0] wb_dat_i,
  output logic [cfh_pkg::DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] app_ind_o,
  output logic app_ind_stb_o
);
  import cfh_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0] mem [0:255];
  logic [31:0] cmd_reg, geom_reg, file_reg, sel_reg;
  logic [7:0] madr_reg, cur_reg, cnt_reg, ptr_reg;
  logic ptr_val_reg, done_reg;
  logic [15:0] sw_reg;
  cfh_state_e state_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Bus access
  // ************************************************************
  logic acc, wr, rd, start, pop, push;
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rd = acc & ~wb_we_i;
  assign start = wr & (wb_adr_i == OFS_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_START_BIT] & (state_reg == ST_IDLE);
  assign pop = rd & (wb_adr_i == OFS_DATA) & (state_reg == ST_SEND);
  assign push = wr & (wb_adr_i == OFS_DATA) & wb_sel_i[0] & (state_reg == ST_RECV);

  // ************************************************************
  // Field views
  // ************************************************************
  logic [7:0] ins, p1, p2, le, lc, fsize, reclen, nrec, fcp_len, dfn_len;
  logic [1:0] fstruct;
  logic [4:0] sfr;
  logic rd_ok, up_ok;
  assign ins = cmd_reg[CMD_INS_LSB +: 8];
  assign p1 = cmd_reg[CMD_P1_LSB +: 8];
  assign p2 = cmd_reg[CMD_P2_LSB +: 8];
  assign le = cmd_reg[CMD_LE_LSB +: 8];
  assign lc = geom_reg[GEOM_LC_LSB +: 8];
  assign fsize = geom_reg[GEOM_SIZE_LSB +: 8];
  assign fstruct = file_reg[FILE_ST_LSB +: 2];
  assign rd_ok = file_reg[FILE_RDOK_BIT];
  assign up_ok = file_reg[FILE_UPOK_BIT];
  assign reclen = file_reg[FILE_RLEN_LSB +: 8];
  assign nrec = file_reg[FILE_NREC_LSB +: 8];
  assign sfr = file_reg[FILE_SFR_LSB +: 5];
  assign fcp_len = sel_reg[SEL_FCP_LSB +: 8];
  assign dfn_len = sel_reg[SEL_DFN_LSB +: 8];

  // ************************************************************
  // Command decode
  // ************************************************************
  logic [15:0] d_sw, off, span;
  logic [7:0] d_base, d_len, d_ptr, tgt, cnt;
  logic d_pval, d_recv, d_ind, direct, by_sfr, file_ok, acc_ok;
  logic [2:0] mode;
  assign mode = p2[2:0];
  assign direct = ~p1[7];
  assign by_sfr = p1[7:5] == P1_SFR_TAG;
  assign off = direct ? {1'b0, p1[6:0], p2} : {8'h00, p2};
  assign file_ok = direct | (by_sfr & (p1[4:0] == sfr));
  assign cnt = (ins == CMD_UPD_BIN) ? lc : le;
  assign acc_ok = (ins == CMD_UPD_BIN) ? up_ok : rd_ok;
  assign span = off + {8'h00, cnt};

  always_comb begin
    d_sw = SW_OK;
    d_base = 8'h00;
    d_len = 8'h00;
    d_recv = 1'b0;
    d_ind = 1'b0;
    d_ptr = ptr_reg;
    d_pval = ptr_val_reg;
    tgt = 8'h00;
    case (ins)
      CMD_STATUS: begin
        d_ind = 1'b1;
        if (p2 == P2_SEL) begin
          d_base = FCP_BASE;
          d_len = fcp_len;
        end else if (p2 == P2_DFNAME) begin
          d_base = DFN_BASE;
          d_len = dfn_len;
        end else if (p2 != P2_NODATA) begin
          d_sw = SW_P1P2;
        end
        if ((le != 8'h00) && (d_len > le)) begin
          d_len = le;
        end
      end
      CMD_RD_BIN, CMD_UPD_BIN: begin
        if (!(direct | by_sfr)) begin
          d_sw = SW_P1P2;
        end else if (!file_ok) begin
          d_sw = SW_NOFILE;
        end else if (fstruct != FS_TRANSP) begin
          d_sw = SW_STRUCT;
        end else if (!acc_ok) begin
          d_sw = SW_SEC;
        end else if (cnt == 8'h00) begin
          d_sw = SW_LEN;
        end else if (span > {8'h00, fsize}) begin
          d_sw = SW_OFFSET;
        end else begin
          d_base = off[7:0];
          d_len = cnt;
          d_recv = ins == CMD_UPD_BIN;
        end
      end
      CMD_RD_REC: begin
        if ((p2[7:3] != 5'h00) && (p2[7:3] != sfr)) begin
          d_sw = SW_NOFILE;
        end else if ((fstruct != FS_LINEAR) && (fstruct != FS_CYCLIC)) begin
          d_sw = SW_STRUCT;
        end else if (!rd_ok) begin
          d_sw = SW_SEC;
        end else if (nrec == 8'h00) begin
          d_sw = SW_NOREC;
        end else begin
          if (mode == MODE_ABS) begin
            if (p1 == 8'h00) begin
              tgt = ptr_reg;
              if (!ptr_val_reg) begin
                d_sw = SW_NOREC;
              end
            end else begin
              tgt = p1;
              if (p1 > nrec) begin
                d_sw = SW_NOREC;
              end
            end
          end else if (mode == MODE_NEXT) begin
            if (!ptr_val_reg) begin
              tgt = 8'h01;
            end else if (ptr_reg == nrec) begin
              tgt = 8'h01;
              if (fstruct == FS_LINEAR) begin
                d_sw = SW_NOREC;
              end
            end else begin
              tgt = ptr_reg + 8'h01;
            end
            d_ptr = tgt;
            d_pval = 1'b1;
          end else if (mode == MODE_PREV) begin
            if (!ptr_val_reg) begin
              tgt = nrec;
            end else if (ptr_reg == 8'h01) begin
              tgt = nrec;
              if (fstruct == FS_LINEAR) begin
                d_sw = SW_NOREC;
              end
            end else begin
              tgt = ptr_reg - 8'h01;
            end
            d_ptr = tgt;
            d_pval = 1'b1;
          end else begin
            d_sw = SW_P1P2;
          end
          if ((le != 8'h00) && (le != reclen)) begin
            d_sw = SW_LEN;
          end
          d_base = 8'((tgt - 8'h01) * reclen);
          d_len = reclen;
        end
      end
      default: begin
        d_sw = SW_INS;
      end
    endcase
    if (d_sw != SW_OK) begin
      d_len = 8'h00;
      d_recv = 1'b0;
      d_ind = 1'b0;
      d_ptr = ptr_reg;
      d_pval = ptr_val_reg;
    end
  end

  // ************************************************************
  // Transfer sequencing
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cur_reg <= 8'h00;
      cnt_reg <= 8'h00;
      sw_reg <= SW_OK;
      done_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            cur_reg <= d_base;
            cnt_reg <= d_len;
            sw_reg <= d_sw;
            done_reg <= ~d_recv & (d_len == 8'h00);
            if (d_recv) begin
              state_reg <= ST_RECV;
            end else if (d_len != 8'h00) begin
              state_reg <= ST_SEND;
            end
          end
        end
        ST_SEND, ST_RECV: begin
          if (pop | push) begin
            cur_reg <= cur_reg + 8'h01;
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
              state_reg <= ST_IDLE;
              done_reg <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Pointer forgotten whenever a new file is described
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= 8'h00;
      ptr_val_reg <= 1'b0;
    end else if (wr & (wb_adr_i == OFS_FILE)) begin
      ptr_reg <= 8'h00;
      ptr_val_reg <= 1'b0;
    end else if (start & (ins == CMD_RD_REC)) begin
      ptr_reg <= d_ptr;
      ptr_val_reg <= d_pval;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      app_ind_o <= 8'h00;
      app_ind_stb_o <= 1'b0;
    end else begin
      app_ind_stb_o <= start & d_ind;
      if (start & d_ind) begin
        app_ind_o <= p1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[cur_reg] <= wb_dat_i[7:0];
    end else if (wr & (wb_adr_i == OFS_MDAT) & wb_sel_i[0]) begin
      mem[madr_reg] <= wb_dat_i[7:0];
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= RST_WORD;
      geom_reg <= RST_WORD;
      file_reg <= RST_WORD;
      sel_reg <= RST_WORD;
      madr_reg <= 8'h00;
    end else if (wr) begin
      if (wb_adr_i == OFS_CMD) begin
        cmd_reg <= merge(cmd_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_GEOM) begin
        geom_reg <= merge(geom_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_FILE) begin
        file_reg <= merge(file_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_SEL) begin
        sel_reg <= merge(sel_reg, wb_dat_i, wb_sel_i);
      end else if ((wb_adr_i == OFS_MADR) & wb_sel_i[0]) begin
        madr_reg <= wb_dat_i[7:0];
      end
    end
  end

  logic [31:0] rdata;
  always_comb begin
    rdata = RST_WORD;
    if (wb_adr_i == OFS_CMD) begin
      rdata = cmd_reg;
    end else if (wb_adr_i == OFS_GEOM) begin
      rdata = geom_reg;
    end else if (wb_adr_i == OFS_FILE) begin
      rdata = file_reg;
    end else if (wb_adr_i == OFS_SEL) begin
      rdata = sel_reg;
    end else if (wb_adr_i == OFS_STAT) begin
      rdata = {cnt_reg, sw_reg, 5'h00, state_reg != ST_IDLE, done_reg, 1'b0};
    end else if (wb_adr_i == OFS_PTR) begin
      rdata = {23'h00_0000, ptr_val_reg, ptr_reg};
    end else if (wb_adr_i == OFS_DATA) begin
      rdata = (state_reg == ST_SEND) ? {24'h00_0000, mem[cur_reg]} : RST_WORD;
    end else if (wb_adr_i == OFS_MADR) begin
      rdata = {24'h00_0000, madr_reg};
    end else if (wb_adr_i == OFS_MDAT) begin
      rdata = {24'h00_0000, mem[madr_reg]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_WORD;
    end else begin
      wb_ack_o <= acc;
      if (rd) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rec_go;
  assign rec_go = start & (ins == CMD_RD_REC);

  chk_ack_single: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");
  chk_fail_ptr_kept: assert property (rec_go && d_sw != SW_OK |=> $stable(ptr_reg) && $stable(ptr_val_reg))
    else $error("failed record read moved pointer");
  chk_abs_ptr_kept: assert property (rec_go && mode == MODE_ABS |=> $stable(ptr_reg))
    else $error("absolute read moved pointer");
  chk_next_first: assert property (rec_go && mode == MODE_NEXT && !ptr_val_reg && d_sw == SW_OK
    |=> ptr_reg == 8'h01 && ptr_val_reg && cnt_reg == reclen)
    else $error("next without pointer not first record");
  chk_linear_end: assert property (rec_go && mode == MODE_NEXT && fstruct == FS_LINEAR && rd_ok
    && ptr_val_reg && ptr_reg == nrec && nrec != 8'h00 && p2[7:3] == 5'h00 && (le == 8'h00 || le == reclen)
    |=> sw_reg == SW_NOREC && cnt_reg == 8'h00 && state_reg == ST_IDLE && $stable(ptr_reg))
    else $error("linear next at last record not refused");
  chk_cyclic_wrap: assert property (rec_go && mode == MODE_NEXT && fstruct == FS_CYCLIC
    && ptr_val_reg && ptr_reg == nrec && d_sw == SW_OK |=> ptr_reg == 8'h01)
    else $error("cyclic next did not wrap");
  chk_prev_wrap: assert property (rec_go && mode == MODE_PREV && fstruct == FS_CYCLIC
    && ptr_val_reg && ptr_reg == 8'h01 && d_sw == SW_OK |=> ptr_reg == $past(nrec))
    else $error("cyclic previous did not wrap");
  chk_read_count: assert property (start && ins == CMD_RD_BIN && d_sw == SW_OK
    |=> cnt_reg == $past(le) && state_reg == ST_SEND)
    else $error("read count differs from expected length");
  chk_read_denied: assert property (start && ins == CMD_RD_BIN && !rd_ok && file_ok
    && fstruct == FS_TRANSP |=> sw_reg == SW_SEC && cnt_reg == 8'h00)
    else $error("read without access not refused");
  chk_status_rsvd: assert property (start && ins == CMD_STATUS && p2 != P2_SEL && p2 != P2_DFNAME
    && p2 != P2_NODATA |=> sw_reg == SW_P1P2 && state_reg == ST_IDLE && !app_ind_stb_o)
    else $error("reserved status coding accepted");
  chk_app_ind: assert property (start && ins == CMD_STATUS && p2 == P2_NODATA
    |=> app_ind_stb_o && app_ind_o == $past(p1) ##1 !app_ind_stb_o)
    else $error("application indication not passed");
endmodule

/* File: cfh_terminal.sv */
`timescale 1ns/100ps
module cfh_terminal (
  input wire logic clk_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [cfh_pkg::AW-1:0] adr_o,
  output logic [3:0] sel_o,
  output logic [cfh_pkg::DW-1:0] dat_o,
  input wire logic [cfh_pkg::DW-1:0] dat_i,
  input wire logic ack_i
);
  import cfh_pkg::*;
  logic [7:0] file_size = 8'h20;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    dat_o = 32'h0000_0000;
  end
  // ********
  // Single classic cycle, held until ack
  // ********
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // ********
  // Command issue
  // ********
  task automatic apdu(input logic [7:0] ins, p1, p2, le, lc);
    if (ins == CMD_RD_BIN) lc = 8'h00;
    if (ins == CMD_UPD_BIN) le = 8'h00;
    if (ins == CMD_RD_REC && p2[2:0] inside {MODE_NEXT, MODE_PREV}) p1 = 8'h00;
    wr(OFS_GEOM, {16'h0000, file_size, lc});
    wr(OFS_CMD, {le, p2, p1, ins});
    wr(OFS_CTRL, 32'h0000_0001);
  endtask
endmodule

/* File: cfh_top_bench.sv */
`timescale 1ns/100ps
module cfh_top_bench;
  import cfh_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, ind_stb;
  logic [7:0] adr, ind;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int fail_count = 0;
  int checks = 0;
  int ind_pulses = 0;
  cfh_top i_cfh_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .app_ind_o(ind), .app_ind_stb_o(ind_stb));
  cfh_terminal i_cfh_terminal (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (ind_stb === 1'b1) begin
      ind_pulses <= ind_pulses + 1;
    end
  end
  // ********
  // Helpers
  // ********
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  function automatic logic [31:0] fw(input logic [1:0] st, input logic r, u, input logic [7:0] rl, nr);
    return {3'h0, 5'h05, nr, rl, 4'h0, u, r, st};
  endfunction
  task automatic run(input logic [7:0] ins, p1, p2, le, input logic [15:0] sw, input logic [7:0] n, b);
    i_cfh_terminal.apdu(ins, p1, p2, le, 8'h00);
    i_cfh_terminal.rd(OFS_STAT, q);
    chk("status word", {16'h0000, sw}, {16'h0000, q[23:8]});
    chk("length", {24'h00_0000, n}, {24'h00_0000, q[31:24]});
    for (int i = 0; i < n; i++) begin
      i_cfh_terminal.rd(OFS_DATA, q);
      chk("data byte", {24'h00_0000, pat(b + i[7:0])}, {24'h00_0000, q[7:0]});
    end
    i_cfh_terminal.rd(OFS_STAT, q);
    chk("done not busy", 32'h0000_0001, {30'h0000_0000, q[2:1]});
  endtask
  task automatic ptr(input logic [7:0] e);
    i_cfh_terminal.rd(OFS_PTR, q);
    if (e == 8'h00) chk("pointer valid", 32'h0000_0000, {31'h0000_0000, q[8]});
    else chk("pointer", {23'h00_0000, 1'b1, e}, {23'h00_0000, q[8:0]});
  endtask
  task automatic mem(input logic [7:0] a, input logic [7:0] e);
    i_cfh_terminal.wr(OFS_MADR, {24'h00_0000, a});
    i_cfh_terminal.rd(OFS_MDAT, q);
    chk("memory", {24'h00_0000, e}, {24'h00_0000, q[7:0]});
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    i_cfh_terminal.rd(OFS_STAT, q);
    chk("reset status", {8'h00, SW_OK, 8'h00}, {q[31:1], 1'b0});
    ptr(8'h00);
    i_cfh_terminal.wr(8'h80, 32'hFFFF_FFFF);
    i_cfh_terminal.rd(8'h80, q);
    chk("unmapped", 32'h0000_0000, q);
    for (int i = 0; i < 48; i++) begin
      q[7:0] = i < 32 ? 8'(i) : (i < 40 ? 8'(i + 160) : 8'(i + 184));
      i_cfh_terminal.wr(OFS_MADR, {24'h00_0000, q[7:0]});
      i_cfh_terminal.wr(OFS_MDAT, {24'h00_0000, pat(q[7:0])});
    end
    i_cfh_terminal.wr(OFS_SEL, 32'h0000_0305);
  endtask
  task automatic t_status;
    run(CMD_STATUS, 8'h01, P2_SEL, 8'h00, SW_OK, 8'h05, FCP_BASE);
    chk("indication", 32'h0000_0001, {24'h00_0000, ind});
    chk("indication pulses", 32'h0000_0001, ind_pulses);
    run(CMD_STATUS, 8'h02, P2_DFNAME, 8'h02, SW_OK, 8'h02, DFN_BASE);
    run(CMD_STATUS, 8'h02, P2_NODATA, 8'h00, SW_OK, 8'h00, 8'h00);
    run(CMD_STATUS, 8'h03, 8'h05, 8'h00, SW_P1P2, 8'h00, 8'h00);
    chk("indication", 32'h0000_0002, {24'h00_0000, ind});
    run(8'h07, 8'h00, 8'h00, 8'h00, SW_INS, 8'h00, 8'h00);
    chk("indication pulses", 32'h0000_0003, ind_pulses);
  endtask
  task automatic t_binary;
    i_cfh_terminal.wr(OFS_FILE, fw(FS_TRANSP, 1'b1, 1'b1, 8'h00, 8'h00));
    run(CMD_RD_BIN, 8'h00, 8'h10, 8'h04, SW_OK, 8'h04, 8'h10);
    run(CMD_RD_BIN, 8'h00, 8'h00, 8'h00, SW_LEN, 8'h00, 8'h00);
    run(CMD_RD_BIN, 8'h00, 8'h1C, 8'h04, SW_OK, 8'h04, 8'h1C);
    run(CMD_RD_BIN, 8'h01, 8'h00, 8'h01, SW_OFFSET, 8'h00, 8'h00);
    run(CMD_RD_BIN, 8'h85, 8'h02, 8'h03, SW_OK, 8'h03, 8'h02);
    run(CMD_RD_BIN, 8'h86, 8'h02, 8'h03, SW_NOFILE, 8'h00, 8'h00);
    run(CMD_RD_BIN, 8'hA5, 8'h02, 8'h03, SW_P1P2, 8'h00, 8'h00);
    i_cfh_terminal.wr(OFS_FILE, fw(FS_TRANSP, 1'b0, 1'b1, 8'h00, 8'h00));
    run(CMD_RD_BIN, 8'h00, 8'h00, 8'h01, SW_SEC, 8'h00, 8'h00);
    i_cfh_terminal.apdu(CMD_UPD_BIN, 8'h00, 8'h18, 8'h00, 8'h03);
    i_cfh_terminal.rd(OFS_STAT, q);
    chk("update status", {16'h0000, SW_OK}, {16'h0000, q[23:8]});
    for (int i = 0; i < 3; i++) i_cfh_terminal.wr(OFS_DATA, 32'h0000_00A0 + i);
    i_cfh_terminal.rd(OFS_STAT, q);
    chk("update done", 32'h0000_0001, {30'h0000_0000, q[2:1]});
    for (int i = 0; i < 4; i++) mem(8'h18 + 8'(i), i < 3 ? 8'hA0 + 8'(i) : pat(8'h1B));
    i_cfh_terminal.wr(OFS_FILE, fw(FS_TRANSP, 1'b1, 1'b0, 8'h00, 8'h00));
    run(CMD_UPD_BIN, 8'h00, 8'h0C, 8'h00, SW_SEC, 8'h00, 8'h00);
    mem(8'h0C, pat(8'h0C));
    i_cfh_terminal.wr(OFS_FILE, fw(FS_LINEAR, 1'b1, 1'b1, 8'h04, 8'h03));
    run(CMD_RD_BIN, 8'h00, 8'h00, 8'h01, SW_STRUCT, 8'h00, 8'h00);
  endtask
  task automatic t_record;
    run(CMD_RD_REC, 8'h00, 8'h02, 8'h00, SW_OK, 8'h04, 8'h00);
    ptr(8'h01);
    run(CMD_RD_REC, 8'h00, 8'h02, 8'h04, SW_OK, 8'h04, 8'h04);
    run(CMD_RD_REC, 8'h00, 8'h02, 8'h00, SW_OK, 8'h04, 8'h08);
    run(CMD_RD_REC, 8'h00, 8'h02, 8'h00, SW_NOREC, 8'h00, 8'h00);
    ptr(8'h03);
    run(CMD_RD_REC, 8'h00, 8'h03, 8'h00, SW_OK, 8'h04, 8'h04);
    run(CMD_RD_REC, 8'h01, 8'h04, 8'h00, SW_OK, 8'h04, 8'h00);
    run(CMD_RD_REC, 8'h00, 8'h04, 8'h00, SW_OK, 8'h04, 8'h04);
    ptr(8'h02);
    run(CMD_RD_REC, 8'h02, 8'h2C, 8'h00, SW_OK, 8'h04, 8'h04);
    run(CMD_RD_REC, 8'h00, 8'h03, 8'h00, SW_OK, 8'h04, 8'h00);
    run(CMD_RD_REC, 8'h00, 8'h03, 8'h00, SW_NOREC, 8'h00, 8'h00);
    run(CMD_RD_REC, 8'h04, 8'h04, 8'h00, SW_NOREC, 8'h00, 8'h00);
    run(CMD_RD_REC, 8'h00, 8'h05, 8'h00, SW_P1P2, 8'h00, 8'h00);
    ptr(8'h01);
    i_cfh_terminal.wr(OFS_FILE, fw(FS_CYCLIC, 1'b1, 1'b0, 8'h04, 8'h03));
    ptr(8'h00);
    run(CMD_RD_REC, 8'h00, 8'h04, 8'h00, SW_NOREC, 8'h00, 8'h00);
    ptr(8'h00);
    run(CMD_RD_REC, 8'h00, 8'h03, 8'h00, SW_OK, 8'h04, 8'h08);
    run(CMD_RD_REC, 8'h00, 8'h02, 8'h00, SW_OK, 8'h04, 8'h00);
    ptr(8'h01);
    run(CMD_RD_REC, 8'h00, 8'h03, 8'h00, SW_OK, 8'h04, 8'h08);
    ptr(8'h03);
    run(CMD_RD_REC, 8'h00, 8'h04, 8'h02, SW_LEN, 8'h00, 8'h00);
    run(CMD_RD_REC, 8'h01, 8'h34, 8'h00, SW_NOFILE, 8'h00, 8'h00);
    ptr(8'h03);
    i_cfh_terminal.wr(OFS_FILE, fw(FS_TRANSP, 1'b1, 1'b0, 8'h00, 8'h00));
    run(CMD_RD_REC, 8'h01, 8'h04, 8'h00, SW_STRUCT, 8'h00, 8'h00);
  endtask
  // ********
  // Sequence and verdict
  // ********
  task automatic results;
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_status;
    t_binary;
    t_record;
    results;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    results;
  end
endmodule
